// ### common/bptg_map.svh
// What this block does
// - In short_selftest_position-test, top address nibble equals or complements the next nibble.
// - Short_selftest_position-test steps upper bytes 00,11..FF, then complemented pairing F0,E1..0F.
// - Lowest address bit comes from the lookup table, not the counter.
// - Data is the complement of the address bits, except data bit 0.
// - Short_selftest_position-test gives a short reset pulse over the first four steps after the wrap to address zero.
// - Full program counts address bits 19 to 1 from all zeros to ones.
// - Full program exercises hold, grants, ready, reset, interrupt from 80000 up.
// - On a bus-mode change, freeze pattern outputs about 50 ms, reset held.
// - A 32 by 8 table gives an 8-step program for queue and status lines.
// - Short_selftest_position-test runs short maximum-mode program; full program covers both modes when the bus-mode jumper picks alternation.
// - The skip jumper removes the freeze on a bus-mode change.
// - While halt is asserted, address, data and control outputs stay unchanged.
// - Bus-mode jumper picks fixed minimum, fixed maximum or alternation.
// - Clock-source jumper picks internal divider or external test clock.
// - Lowest address bit is driven only while its enable jumper is fitted.
// - Start and stop gating pulses bracket one pattern pass.
`ifndef BPTG_MAP_SVH
`define BPTG_MAP_SVH
`define BPTG_CLK_HZ 10000000
`define BPTG_FREEZE_MS 50
`define BPTG_FREEZE_CYC (`BPTG_CLK_HZ / 1000 * `BPTG_FREEZE_MS)
`define BPTG_INT_DIV 4'hA
`define BPTG_RST_STEPS 16'h0004
`define BPTG_SHORT_SELFTEST_POSITION_LAST 16'hFFFF
`define BPTG_CTRL_BIT 18
`define BPTG_CNT_RST 19'h00000
`define BPTG_FZ_RST 20'h00000
`define BPTG_DIV_RST 4'h0
`define BPTG_PROM_A0 5
`define BPTG_PROM_NMI 6
`define BPTG_PROM_UBE 7
`endif

// ### common/bptg_pkg.sv
package bptg_pkg;
  typedef enum logic [1:0] {
    BPTG_MODE_MIN = 2'b00,
    BPTG_MODE_MAX = 2'b01,
    BPTG_MODE_ALT = 2'b10
  } bptg_mode_e;
  typedef enum logic {
    BPTG_RUN = 1'b0,
    BPTG_FREEZE = 1'b1
  } bptg_state_e;
  typedef logic [7:0] bptg_prom_t;
  typedef struct packed {
    logic hold;
    logic bus_hold_grant;
    logic request_grant_line_zero;
    logic request_grant_line_one;
    logic ready;
    logic interrupt_request;
    logic nmi;
    logic upper_byte_enable;
    logic [2:0] status;
    logic [1:0] queue_status;
  } bptg_ctrl_s;
endpackage

// ### core/bptg_gen.sv
`timescale 1ns/1ns
`include "bptg_map.svh"
module bptg_gen #(
  parameter int unsigned FREEZE_CYCLES = `BPTG_FREEZE_CYC
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_short_selftest_position,
  input wire logic i_skip_mode_change_delay,
  input wire logic i_clock_source_select,
  input wire logic i_ext_test_clk,
  input wire logic i_halt,
  input wire bptg_pkg::bptg_mode_e i_bus_mode_sel,
  input wire logic i_grant_line_sel,
  input wire logic i_addr0_enable,
  output logic [19:0] o_addr,
  output logic o_addr0_oe,
  output logic [15:0] o_data,
  output bptg_pkg::bptg_ctrl_s o_ctrl,
  output logic o_reset,
  output logic o_min_mode,
  output logic o_sa_start,
  output logic o_sa_stop
);

  localparam logic [19:0] FZ_LAST = 20'(FREEZE_CYCLES - 1);

  logic [3:0] div_q;
  logic ext_q;
  logic tick;
  logic advance;
  logic [18:0] cnt_q;
  logic [18:0] cnt_d;
  logic last;
  logic min_q;
  logic min_d;
  logic [19:0] fz_q;
  bptg_pkg::bptg_state_e state_q;
  bptg_pkg::bptg_prom_t prom;
  logic [19:0] addr_d;
  logic short_selftest_position_rst;
  logic full_rst;
  logic step_min;
  logic freeze_go;

  // Lookup table; index is test bank, mode bank and 3-bit step, repeating every 8 addresses.
  function automatic bptg_pkg::bptg_prom_t prom_lookup(input logic [4:0] idx);
    bptg_pkg::bptg_prom_t v;
    v = 8'h00;
    case (idx)
      5'h00: v = 8'h84;
      5'h01: v = 8'h21;
      5'h02: v = 8'h4A;
      5'h03: v = 8'h13;
      5'h04: v = 8'hA6;
      5'h05: v = 8'h0D;
      5'h06: v = 8'h62;
      5'h07: v = 8'h17;
      5'h08: v = 8'h85;
      5'h09: v = 8'h20;
      5'h0A: v = 8'h4B;
      5'h0B: v = 8'h12;
      5'h0C: v = 8'hA7;
      5'h0D: v = 8'h0C;
      5'h0E: v = 8'h63;
      5'h0F: v = 8'h16;
      5'h10: v = 8'h80;
      5'h11: v = 8'h29;
      5'h12: v = 8'h42;
      5'h13: v = 8'h1B;
      5'h14: v = 8'hA4;
      5'h15: v = 8'h09;
      5'h16: v = 8'h6A;
      5'h17: v = 8'h11;
      5'h18: v = 8'h81;
      5'h19: v = 8'h28;
      5'h1A: v = 8'h43;
      5'h1B: v = 8'h1A;
      5'h1C: v = 8'hA5;
      5'h1D: v = 8'h08;
      5'h1E: v = 8'h6B;
      5'h1F: v = 8'h10;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // Builds the 20-bit address from the counter and the table's bit 5.
  function automatic logic [19:0] build_addr(
    input logic [18:0] c,
    input logic short_selftest_position_pos,
    input logic a0
  );
    logic [19:0] a;
    a = {c, a0};
    if (short_selftest_position_pos)
    begin
      a[19:16] = c[15] ? ~c[14:11] : c[14:11];
    end
    return a;
  endfunction

  // A pass boundary needs a freeze when the mode flips and the skip jumper is out.
  function automatic logic freeze_needed(
    input logic cur_min,
    input logic next_min,
    input logic skip
  );
    return (cur_min != next_min) && !skip;
  endfunction

  // True when a counter value is the final step of a pass.
  function automatic logic pass_end(
    input logic [18:0] c,
    input logic short_selftest_position_pos
  );
    logic e;
    e = &c;
    if (short_selftest_position_pos)
    begin
      e = (c[15:0] == `BPTG_SHORT_SELFTEST_POSITION_LAST);
    end
    return e;
  endfunction

  // Selects the test clock and makes one advance enable per active edge.
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      div_q <= `BPTG_DIV_RST;
      ext_q <= 1'b0;
    end
    else
    begin
      ext_q <= i_ext_test_clk;
      if (div_q == `BPTG_INT_DIV - 4'h1)
      begin
        div_q <= `BPTG_DIV_RST;
      end
      else
      begin
        div_q <= div_q + 4'h1;
      end
    end
  end

  always_comb
  begin
    if (i_clock_source_select)
    begin
      tick = i_ext_test_clk & ~ext_q;
    end
    else
    begin
      tick = (div_q == `BPTG_INT_DIV - 4'h1);
    end
  end

  assign advance = tick & ~i_halt & (state_q == bptg_pkg::BPTG_RUN);

  // Counter wrap and next value; short_selftest_position-test uses only the low 16 counter bits.
  always_comb
  begin
    last = pass_end(cnt_q, i_short_selftest_position);
    if (last)
    begin
      cnt_d = `BPTG_CNT_RST;
    end
    else
    begin
      cnt_d = cnt_q + 19'h00001;
    end
  end

  // Bus mode taken for the next pass; it only changes at the wrap.
  always_comb
  begin
    min_d = min_q;
    if (i_short_selftest_position)
    begin
      min_d = 1'b0;
    end
    else
    begin
      case (i_bus_mode_sel)
        bptg_pkg::BPTG_MODE_MIN: min_d = 1'b1;
        bptg_pkg::BPTG_MODE_MAX: min_d = 1'b0;
        bptg_pkg::BPTG_MODE_ALT: min_d = ~min_q;
        default: min_d = 1'b0;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      cnt_q <= `BPTG_CNT_RST;
    end
    else if (advance)
    begin
      cnt_q <= cnt_d;
    end
  end

  // Mode register and freeze sequencer.
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      min_q <= 1'b0;
      state_q <= bptg_pkg::BPTG_RUN;
      fz_q <= `BPTG_FZ_RST;
    end
    else
    begin
      case (state_q)
        bptg_pkg::BPTG_RUN:
        begin
          if (advance && last)
          begin
            min_q <= min_d;
            if (freeze_go)
            begin
              state_q <= bptg_pkg::BPTG_FREEZE;
              fz_q <= `BPTG_FZ_RST;
            end
          end
        end
        bptg_pkg::BPTG_FREEZE:
        begin
          if (fz_q == FZ_LAST)
          begin
            state_q <= bptg_pkg::BPTG_RUN;
          end
          else
          begin
            fz_q <= fz_q + 20'h00001;
          end
        end
        default:
        begin
          state_q <= bptg_pkg::BPTG_RUN;
        end
      endcase
    end
  end

  // The table and the mode output follow the mode in force for the step being taken.
  assign step_min = last ? min_d : min_q;
  assign freeze_go = advance & last & freeze_needed(min_q, min_d, i_skip_mode_change_delay);
  assign prom = prom_lookup({i_short_selftest_position, step_min, cnt_d[2:0]});
  assign addr_d = build_addr(cnt_d, i_short_selftest_position, prom[`BPTG_PROM_A0]);
  assign short_selftest_position_rst = (cnt_d[15:0] < `BPTG_RST_STEPS);
  assign full_rst = (&cnt_d[10:4]) & cnt_d[`BPTG_CTRL_BIT];

  // Pattern outputs update only on an advance, so halt and freeze hold them.
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_addr <= 20'h00000;
      o_data <= 16'hFFFF;
      o_ctrl <= '0;
      o_min_mode <= 1'b0;
    end
    else if (advance)
    begin
      o_addr <= addr_d;
      o_data <= {~addr_d[15:1], prom[0]};
      o_min_mode <= step_min;
      o_ctrl.status <= prom[2:0];
      o_ctrl.queue_status <= prom[4:3];
      o_ctrl.nmi <= prom[`BPTG_PROM_NMI];
      o_ctrl.upper_byte_enable <= prom[`BPTG_PROM_UBE];
      if (!i_short_selftest_position && cnt_d[`BPTG_CTRL_BIT])
      begin
        o_ctrl.hold <= min_q & cnt_d[3];
        o_ctrl.bus_hold_grant <= min_q & cnt_d[4];
        o_ctrl.request_grant_line_zero <= ~min_q & ~i_grant_line_sel & cnt_d[3];
        o_ctrl.request_grant_line_one <= ~min_q & i_grant_line_sel & cnt_d[3];
        o_ctrl.ready <= ~cnt_d[5];
        o_ctrl.interrupt_request <= cnt_d[6];
      end
      else
      begin
        o_ctrl.hold <= 1'b0;
        o_ctrl.bus_hold_grant <= 1'b0;
        o_ctrl.request_grant_line_zero <= 1'b0;
        o_ctrl.request_grant_line_one <= 1'b0;
        o_ctrl.ready <= 1'b1;
        o_ctrl.interrupt_request <= 1'b0;
      end
    end
  end

  // Reset to the module under test: pattern reset, or held through a freeze.
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_reset <= 1'b0;
    end
    else if (state_q == bptg_pkg::BPTG_FREEZE)
    begin
      o_reset <= 1'b1;
    end
    else if (advance)
    begin
      if (freeze_go)
      begin
        o_reset <= 1'b1;
      end
      else if (i_short_selftest_position)
      begin
        o_reset <= short_selftest_position_rst;
      end
      else
      begin
        o_reset <= full_rst;
      end
    end
  end

  // Signature gating pulses at the first and last step of a pass.
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_sa_start <= 1'b0;
      o_sa_stop <= 1'b0;
    end
    else
    begin
      o_sa_start <= advance & last;
      o_sa_stop <= advance & pass_end(cnt_d, i_short_selftest_position);
    end
  end

  assign o_addr0_oe = i_addr0_enable;

endmodule

// ### sim/bptg_probe.sv
`timescale 1ns/1ns
module bptg_probe (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_reset,
  output logic [7:0] o_resets
);
  logic seen_q;
  // Counts each reset pulse that the generator applies.
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      seen_q <= 1'b0;
      o_resets <= 8'h00;
    end
    else
    begin
      seen_q <= i_reset;
      if (i_reset && !seen_q) o_resets <= o_resets + 8'h01;
    end
  end
endmodule

// ### sim/bptg_gen_props.sv
`timescale 1ns/1ns
module bptg_gen_props #(
  parameter int unsigned FREEZE_CYCLES = 20
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_short_selftest_position,
  input wire logic i_skip_mode_change_delay,
  input wire logic i_halt,
  input wire logic i_addr0_enable,
  input wire logic [19:0] o_addr,
  input wire logic o_addr0_oe,
  input wire logic [15:0] o_data,
  input wire logic o_reset,
  input wire logic o_min_mode,
  input wire logic o_sa_start
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  a_top_nibble: assert property (i_short_selftest_position |->
    o_addr[19:16] == o_addr[15:12] || o_addr[19:16] == ~o_addr[15:12]) else $error("top bad");
  a_data_compl: assert property (o_data[15:1] == ~o_addr[15:1]) else $error("data bad");
  a_a0_enable: assert property (o_addr0_oe == i_addr0_enable) else $error("a0 oe bad");
  a_halt_hold: assert property (i_halt |=> $stable(o_addr) && $stable(o_data))
    else $error("halt moved");
  a_step_one: assert property ($changed(o_addr[11:1]) |->
    o_addr[11:1] == $past(o_addr[11:1]) + 11'h001) else $error("step bad");
  a_start_wrap: assert property (o_sa_start |-> o_addr[11:1] == 11'h000)
    else $error("start bad");
  a_start_pulse: assert property (o_sa_start |=> !o_sa_start) else $error("start long");
  a_short_selftest_position_reset: assert property (i_short_selftest_position && o_addr[19:1] == 19'h00001
    |-> o_reset) else $error("no reset");
  a_short_selftest_position_free: assert property (i_short_selftest_position && o_addr[19:1] == 19'h00010
    |-> !o_reset) else $error("late reset");
  a_mode_freeze: assert property ($changed(o_min_mode) && !i_skip_mode_change_delay
    |=> (o_reset && $stable(o_addr)) [*8]) else $error("no freeze");
endmodule
bind bptg_gen bptg_gen_props #(.FREEZE_CYCLES(FREEZE_CYCLES)) u_props (.i_clk(i_clk),
  .i_arst_n(i_arst_n), .i_short_selftest_position(i_short_selftest_position),
  .i_skip_mode_change_delay(i_skip_mode_change_delay), .i_halt(i_halt),
  .i_addr0_enable(i_addr0_enable), .o_addr(o_addr), .o_addr0_oe(o_addr0_oe),
  .o_data(o_data), .o_reset(o_reset), .o_min_mode(o_min_mode), .o_sa_start(o_sa_start));

// ### sim/tb_bus_probe_test_stimulus_gen.sv
`timescale 1ns/1ns
module tb_bus_probe_test_stimulus_gen;
  logic clk = 0, rst_n = 0, short_selftest_position = 1, skip = 0, csel = 0, ext = 0, halt = 0;
  logic gsel = 0, a0en = 1, oe, rst, minm, sst, ssp;
  bptg_pkg::bptg_mode_e mode = bptg_pkg::BPTG_MODE_ALT;
  logic [19:0] addr;
  logic [15:0] data;
  logic [7:0] resets;
  bptg_pkg::bptg_ctrl_s ctrl;
  int bad_count = 0, check_count = 0;
  initial forever #50 clk = ~clk;
  bptg_gen #(.FREEZE_CYCLES(20)) u_dut (.i_clk(clk), .i_arst_n(rst_n),
    .i_short_selftest_position(short_selftest_position), .i_skip_mode_change_delay(skip),
    .i_clock_source_select(csel), .i_ext_test_clk(ext), .i_halt(halt),
    .i_bus_mode_sel(mode), .i_grant_line_sel(gsel), .i_addr0_enable(a0en),
    .o_addr(addr), .o_addr0_oe(oe), .o_data(data), .o_ctrl(ctrl), .o_reset(rst),
    .o_min_mode(minm), .o_sa_start(sst), .o_sa_stop(ssp));
  bptg_probe u_pm (.i_clk(clk), .i_arst_n(rst_n), .i_reset(rst), .o_resets(resets));
  task finish_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
    begin
      $display("All tests passed");
    end
    else
    begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task chk(input logic [19:0] s, input logic [19:0] e);
    check_count++;
    if (s !== e)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, s, e);
    end
  endtask
  function automatic logic [19:0] ex(input logic [18:0] k, input logic sf);
    if (sf) return {1'b0, k[15] ? ~k[14:11] : k[14:11], k[14:0]};
    return {1'b0, k};
  endfunction
  task restart(input logic sf);
    @(negedge clk) rst_n = 0;
    short_selftest_position = sf;
    repeat (2) @(negedge clk);
    rst_n = 1;
  endtask
  task step;
    logic [19:0] p;
    int i;
    p = addr;
    i = 0;
    while (addr === p && i < 30)
    begin
      @(negedge clk);
      i++;
    end
  endtask
  task t_short_selftest_position;
    logic [19:0] e;
    logic [8:0] hist [1:20];
    mode = bptg_pkg::BPTG_MODE_MIN;
    restart(1'b1);
    for (int k = 1; k <= 20; k++)
    begin
      step;
      e = ex(19'(k), 1'b1);
      hist[k] = {ctrl.status, ctrl.queue_status, ctrl.nmi, ctrl.upper_byte_enable,
        addr[0], data[0]};
      chk({1'b0, addr[19:1]}, e);
      chk({5'h00, data[15:1]}, {5'h00, ~e[14:0]});
      chk({19'h00000, rst}, {19'h00000, k < 4});
      chk({18'h00000, minm, sst | ssp}, 20'h00000);
      chk({14'h0000, ctrl.hold, ctrl.bus_hold_grant, ctrl.request_grant_line_zero,
        ctrl.request_grant_line_one, ctrl.ready, ctrl.interrupt_request}, 20'h00002);
      if (k > 8) chk({11'h000, hist[k]}, {11'h000, hist[k - 8]});
    end
    chk({12'h000, resets}, 20'h00001);
    $display("t_short_selftest_position done");
  endtask
  task t_full;
    mode = bptg_pkg::BPTG_MODE_ALT;
    restart(1'b0);
    for (int k = 1; k <= 6; k++)
    begin
      step;
      chk({1'b0, addr[19:1]}, ex(19'(k), 1'b0));
      chk({18'h00000, rst, minm}, 20'h00000);
      chk({14'h0000, ctrl.hold, ctrl.bus_hold_grant, ctrl.request_grant_line_zero,
        ctrl.request_grant_line_one, ctrl.ready, ctrl.interrupt_request}, 20'h00002);
    end
    $display("t_full done");
  endtask
  task t_ext;
    csel = 1;
    restart(1'b1);
    for (int k = 1; k <= 5; k++)
    begin
      halt = (k == 5);
      @(negedge clk) ext = 1;
      @(negedge clk) ext = 0;
      repeat (2) @(negedge clk);
      chk({1'b0, addr[19:1]}, ex(19'(k == 5 ? 4 : k), 1'b1));
    end
    halt = 0;
    csel = 0;
    $display("t_ext done");
  endtask
  task t_a0;
    for (int i = 0; i < 2; i++)
    begin
      @(negedge clk) a0en = i[0];
      #1 chk({19'h00000, oe}, {19'h00000, i[0]});
    end
    $display("t_a0 done");
  endtask
  // Host side: trailer pair must be complementary; returns 8 when every bit differs.
  function automatic logic [3:0] trailer_bad_bit(input logic [7:0] lo, input logic [7:0] hi);
    for (int b = 0; b < 8; b++)
    begin
      if (lo[b] == hi[b]) return 4'(b);
    end
    return 4'h8;
  endfunction
  // Host side: 16-bit sum over the bytes of a small module image.
  function automatic logic [15:0] rom_sum(input logic [31:0] img);
    logic [15:0] s;
    s = 16'h0000;
    for (int b = 0; b < 4; b++)
    begin
      s = s + {8'h00, img[b * 8 +: 8]};
    end
    return s;
  endfunction
  task t_host;
    chk({16'h0000, trailer_bad_bit(8'h3C, 8'hC3)}, 20'h00008);
    chk({16'h0000, trailer_bad_bit(8'h3C, 8'hC7)}, 20'h00002);
    chk({4'h0, rom_sum(32'hFFFF3CC3)}, 20'h002FD);
    $display("t_host done");
  endtask
  initial
  begin
    #1000000 bad_count++;
    finish_test;
  end
  initial
  begin
    repeat (20) @(negedge clk);
    rst_n = 1;
    t_short_selftest_position;
    t_full;
    t_ext;
    t_a0;
    t_host;
    finish_test;
  end
endmodule
